// *** core/suart_core.v ***
// Pin-based asynchronous serial transmitter and receiver
`timescale 1ns/100ps
`include "suart_defines.vh"
module suart_core #(
  parameter HALF_W = `SUART_HALF_W,
  parameter BAUD = `SUART_BAUD_DEFAULT,
  parameter FAST_BAUD = `SUART_BAUD_FAST
) (
  input wire clk_sys,
  input wire rst,
  input wire ce,
  input wire fast_rate,
  input wire [`SUART_PIN_SEL_W-1:0] rx_pin_sel,
  input wire [`SUART_PIN_SEL_W-1:0] tx_pin_sel,
  input wire [`SUART_PIN_COUNT-1:0] port_in,
  output reg [`SUART_PIN_COUNT-1:0] port_out,
  output reg [`SUART_PIN_COUNT-1:0] port_oe,
  input wire tx_valid,
  input wire [`SUART_DATA_BITS-1:0] tx_data,
  output wire tx_ready,
  output reg rx_valid,
  output reg [`SUART_DATA_BITS-1:0] rx_data,
  input wire rx_ready
);
  // ---------------------------------------------------------------------
  // Rate selection
  // ---------------------------------------------------------------------
  localparam integer HALF_SLOW_I = `SUART_HALF_CYC(BAUD);
  localparam integer HALF_FAST_I = `SUART_HALF_CYC(FAST_BAUD);
  localparam [HALF_W-1:0] HALF_SLOW = HALF_SLOW_I[HALF_W-1:0];
  localparam [HALF_W-1:0] HALF_FAST = HALF_FAST_I[HALF_W-1:0];
  wire [HALF_W-1:0] half_len;
  assign half_len = fast_rate ? HALF_FAST : HALF_SLOW;
  // ---------------------------------------------------------------------
  // Pin selection and initialisation
  // ---------------------------------------------------------------------
  localparam [1:0] I_RESET = 2'h0;
  localparam [1:0] I_LOAD = 2'h1;
  localparam [1:0] I_RUN = 2'h2;
  reg [1:0] init_state;
  reg tx_line;
  wire rx_line;
  assign rx_line = port_in[rx_pin_sel];
  always @(posedge clk_sys) begin
    if (rst) begin
      init_state <= I_RESET;
      port_out <= {`SUART_PIN_COUNT{1'b0}};
      port_oe <= {`SUART_PIN_COUNT{1'b0}};
    end else if (ce) begin
      case (init_state)
        I_RESET: begin
          port_out[tx_pin_sel] <= `SUART_IDLE_LEVEL;
          init_state <= I_LOAD;
        end
        I_LOAD: begin
          port_oe <= {`SUART_PIN_COUNT{1'b0}};
          port_oe[tx_pin_sel] <= 1'b1;
          init_state <= I_RUN;
        end
        I_RUN: begin
          port_out <= {`SUART_PIN_COUNT{1'b0}};
          port_out[tx_pin_sel] <= tx_line;
          port_oe <= {`SUART_PIN_COUNT{1'b0}};
          port_oe[tx_pin_sel] <= 1'b1;
        end
        default: begin
          init_state <= I_RESET;
        end
      endcase
    end
  end
  wire running;
  assign running = init_state == I_RUN;
  // ---------------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------------
  localparam [1:0] R_IDLE = 2'h0;
  localparam [1:0] R_START = 2'h1;
  localparam [1:0] R_DATA = 2'h2;
  localparam [1:0] R_STOP = 2'h3;
  reg [1:0] rx_state;
  reg rx_prev;
  reg rx_phase;
  reg [`SUART_CNT_W-1:0] rx_count;
  reg [`SUART_DATA_BITS-1:0] rx_shift;
  reg rx_start;
  wire rx_tick;
  wire rx_fall;
  assign rx_fall = rx_prev && !rx_line;
  suart_half_timer #(.W(HALF_W)) u_rx_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .start(rx_start),
    .half_len(half_len),
    .tick(rx_tick)
  );
  always @(posedge clk_sys) begin
    if (rst) begin
      rx_state <= R_IDLE;
      rx_prev <= 1'b1;
      rx_phase <= 1'b0;
      rx_count <= {`SUART_CNT_W{1'b0}};
      rx_shift <= {`SUART_DATA_BITS{1'b0}};
      rx_start <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= {`SUART_DATA_BITS{1'b0}};
    end else if (ce) begin
      rx_prev <= rx_line;
      rx_start <= 1'b0;
      if (rx_valid && rx_ready) begin
        rx_valid <= 1'b0;
      end
      case (rx_state)
        R_IDLE: begin
          if (running && rx_fall) begin
            rx_start <= 1'b1;
            rx_state <= R_START;
          end
        end
        R_START: begin
          if (rx_tick) begin
            rx_phase <= 1'b0;
            rx_count <= {`SUART_CNT_W{1'b0}};
            rx_state <= R_DATA;
          end
        end
        R_DATA: begin
          if (rx_tick) begin
            rx_phase <= !rx_phase;
            if (rx_phase) begin
              rx_shift <= {rx_line, rx_shift[`SUART_DATA_BITS-1:1]};
              rx_count <= rx_count + {{(`SUART_CNT_W-1){1'b0}}, 1'b1};
              if (rx_count == `SUART_DATA_BITS - 1) begin
                rx_state <= R_STOP;
                rx_phase <= 1'b0;
              end
            end
          end
        end
        R_STOP: begin
          rx_data <= rx_shift;
          rx_valid <= 1'b1;
          rx_state <= R_IDLE;
        end
        default: begin
          rx_state <= R_IDLE;
        end
      endcase
    end
  end
  // ---------------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------------
  localparam [1:0] T_IDLE = 2'h0;
  localparam [1:0] T_SEND = 2'h1;
  reg [1:0] tx_state;
  reg [`SUART_DATA_BITS+1:0] tx_shift;
  reg [`SUART_CNT_W-1:0] tx_count;
  reg tx_phase;
  reg tx_start;
  wire tx_tick;
  assign tx_ready = running && tx_state == T_IDLE && !tx_start;
  suart_half_timer #(.W(HALF_W)) u_tx_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .start(tx_start),
    .half_len(half_len),
    .tick(tx_tick)
  );
  always @(posedge clk_sys) begin
    if (rst) begin
      tx_state <= T_IDLE;
      tx_line <= `SUART_IDLE_LEVEL;
      tx_shift <= {(`SUART_DATA_BITS+2){1'b1}};
      tx_count <= {`SUART_CNT_W{1'b0}};
      tx_phase <= 1'b0;
      tx_start <= 1'b0;
    end else if (ce) begin
      tx_start <= 1'b0;
      case (tx_state)
        T_IDLE: begin
          tx_line <= `SUART_IDLE_LEVEL;
          if (tx_ready && tx_valid) begin
            tx_shift <= {1'b1, tx_data, 1'b0};
            tx_line <= 1'b0;
            tx_count <= {`SUART_CNT_W{1'b0}};
            tx_phase <= 1'b0;
            tx_start <= 1'b1;
            tx_state <= T_SEND;
          end
        end
        T_SEND: begin
          if (tx_tick) begin
            tx_phase <= !tx_phase;
            if (tx_phase) begin
              if (tx_count == `SUART_DATA_BITS + 1) begin
                tx_line <= `SUART_IDLE_LEVEL;
                tx_state <= T_IDLE;
              end else begin
                tx_shift <= {1'b1, tx_shift[`SUART_DATA_BITS+1:1]};
                tx_line <= tx_shift[1];
                tx_count <= tx_count + {{(`SUART_CNT_W-1){1'b0}}, 1'b1};
              end
            end
          end
        end
        default: begin
          tx_state <= T_IDLE;
        end
      endcase
    end
  end
endmodule // suart_core

// *** common/suart_defines.vh ***
// Constants of the pin-based serial transmitter and receiver
// ---------------------------------------------------------------------
// Functional notes
// - After reset the transmit pin drives the idle high level before it is enabled as an output.
// - The receiver stays idle until the receive line goes low and takes that fall as the start bit.
// - Eight data bits are sampled once each at their bit centre and the byte is then delivered.
// - The stop bit level is not checked and no framing error exists.
// - One sample per bit is taken with no oversampling or voting.
// - All bit timing is built from one adjustable half-bit delay unit per direction.
// - The link runs at 2400 baud by default and both ends use the same rate.
// - 9600 baud may be chosen as an option once the system is proven at that rate.
// - The bit period is a fixed count of enabled clock cycles and only a low ce pauses its timing.
// - One configurable pin receives and another transmits.
// - Start detection is edge driven and bit timing uses a counter instead of busy loops.
// ---------------------------------------------------------------------
`ifndef SUART_DEFINES_VH
`define SUART_DEFINES_VH
`define SUART_CLK_HZ 200000000
`define SUART_BAUD_DEFAULT 2400
`define SUART_BAUD_FAST 9600
`define SUART_HALF_CYC(b) (`SUART_CLK_HZ / (2 * (b)))
`define SUART_HALF_W 16
`define SUART_DATA_BITS 8
`define SUART_CNT_W 4
`define SUART_PIN_SEL_W 3
`define SUART_PIN_COUNT 8
`define SUART_IDLE_LEVEL 1'b1
`endif

// *** core/suart_half_timer.v ***
// Half-bit delay unit that counts clock cycles
`timescale 1ns/100ps
`include "suart_defines.vh"
module suart_half_timer #(
  parameter W = `SUART_HALF_W
) (
  clk_sys,
  rst,
  ce,
  start,
  half_len,
  tick
);
  input clk_sys;
  input rst;
  input ce;
  input start;
  input [W-1:0] half_len;
  output tick;
  reg [W-1:0] count;
  // Half interval counter, reloaded on start or expiry
  always @(posedge clk_sys) begin
    if (rst) begin
      count <= {W{1'b0}};
    end else if (ce) begin
      if (start || count == {W{1'b0}}) begin
        count <= half_len - {{(W-1){1'b0}}, 1'b1};
      end else begin
        count <= count - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
  assign tick = ce && !start && count == {W{1'b0}};
endmodule // suart_half_timer

// *** test/suart_core_chk.sv ***
// Port checker of the pin serial block
`timescale 1ns/100ps
module suart_core_chk #(
  parameter BAUD = 2400,
  parameter FAST_BAUD = 9600
) (
  input wire clk_sys,
  input wire rst,
  input wire ce,
  input wire fast_rate,
  input wire [2:0] rx_pin_sel,
  input wire [2:0] tx_pin_sel,
  input wire [7:0] port_in,
  input wire [7:0] port_out,
  input wire [7:0] port_oe,
  input wire tx_valid,
  input wire [7:0] tx_data,
  input wire tx_ready,
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_ready
);
  wire tx_line = port_out[tx_pin_sel];
  wire tx_oe = port_oe[tx_pin_sel];
  wire rx_line = port_in[rx_pin_sel];
  wire [7:0] mask = ~(8'h01 << tx_pin_sel);
  wire [31:0] half = 32'hBEBC200 / (2 * (fast_rate ? FAST_BAUD : BAUD));
  reg rx_prev;
  reg [31:0] since_fall;
  reg [31:0] busy_len;
  // Frame timers
  always @(posedge clk_sys) begin
    rx_prev <= rst | rx_line;
    if (rst)
      since_fall <= 32'h7FFFFFFF;
    else if (rx_prev && !rx_line && since_fall >= 18 * half)
      since_fall <= 32'h0;
    else
      since_fall <= since_fall + 32'h1;
    busy_len <= (rst || tx_ready) ? 32'h0 : busy_len + 32'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_take;
    tx_valid && tx_ready && ce;
  endsequence
  a_take_start: assert property (s_take |-> ##2 !tx_ready ##1 !tx_line)
    else $error("start bit late");
  a_oe_after_high: assert property ($rose(tx_oe) |-> $past(tx_line))
    else $error("pin driven before high");
  a_oe_kept: assert property (tx_oe |=> tx_oe)
    else $error("pin released");
  a_pins_used: assert property (((port_oe | port_out) & mask) == 8'h00)
    else $error("foreign pin driven");
  a_frame_len: assert property ($rose(tx_ready) && busy_len > 4 |->
    tx_line && busy_len >= 20 * half - 2 && busy_len <= 20 * half + 4)
    else $error("frame length wrong");
  a_rx_timing: assert property ($rose(rx_valid) |->
    since_fall >= 16 * half && since_fall <= 19 * half)
    else $error("byte delivered off time");
  a_rx_holds: assert property (rx_valid && !rx_ready |=> rx_valid)
    else $error("byte dropped");
  a_rx_clear: assert property (rx_valid && rx_ready |=> !rx_valid)
    else $error("byte not taken");
endmodule // suart_core_chk
bind suart_core suart_core_chk #(.BAUD(BAUD), .FAST_BAUD(FAST_BAUD)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .ce(ce), .fast_rate(fast_rate),
  .rx_pin_sel(rx_pin_sel), .tx_pin_sel(tx_pin_sel), .port_in(port_in),
  .port_out(port_out), .port_oe(port_oe), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
  .rx_data(rx_data), .rx_ready(rx_ready));

// *** test/suart_host.sv ***
// Host serial port model
`timescale 1ns/100ps
module suart_host #(
  parameter H0 = 10,
  parameter H1 = 5
) (
  input wire clk_sys,
  input wire fast,
  input wire dev_tx,
  output logic line
);
  logic [7:0] got_q[$];
  initial line = 1'b1;
  task automatic send(input logic [7:0] d, input logic stop);
    int i;
    int h;
    h = fast ? H1 : H0;
    line <= 1'b0;
    repeat (2 * h) @(posedge clk_sys);
    for (i = 0; i < 9; i++) begin
      line <= (i < 8) ? d[i] : stop;
      repeat (2 * h) @(posedge clk_sys);
    end
    line <= 1'b1;
    repeat (4 * h) @(posedge clk_sys);
  endtask
  // Receive side: centre sampling of the device line
  always @(negedge dev_tx) begin : rx_side
    int h;
    int i;
    logic [7:0] b;
    h = fast ? H1 : H0;
    repeat (h) @(posedge clk_sys);
    for (i = 0; i < 8; i++) begin
      repeat (2 * h) @(posedge clk_sys);
      b[i] = dev_tx;
    end
    got_q.push_back(b);
  end
endmodule // suart_host

// *** test/suart_core_tb.sv ***
// Self-checking bench of the pin serial block
`timescale 1ns/100ps
module suart_core_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic fast_rate = 1'b0;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic rx_ready = 1'b0;
  logic ce = 1'b1;
  logic [2:0] rx_sel = 3'h3;
  logic [2:0] tx_sel = 3'h5;
  wire [7:0] port_in, port_out, port_oe, rx_data;
  wire tx_ready, rx_valid, host_line, dev_tx;
  int err_count = 0;
  int num_checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  assign port_in = {4'hF, host_line, 3'h7};
  assign dev_tx = port_oe[5] ? port_out[5] : 1'b1;
  suart_core #(.BAUD(32'h989680), .FAST_BAUD(32'h1312D00)) u_suart_core (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .fast_rate(fast_rate),
    .rx_pin_sel(rx_sel), .tx_pin_sel(tx_sel), .port_in(port_in),
    .port_out(port_out), .port_oe(port_oe), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready));
  suart_host #(.H0(10), .H1(5)) u_suart_host (.clk_sys(clk_sys),
    .fast(fast_rate), .dev_tx(dev_tx), .line(host_line));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      err_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic print_verdict;
    if (err_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_init;
    repeat (4) @(posedge clk_sys);
    check(port_oe, 8'h20);
    check(port_out, 8'h20);
    check({6'h00, tx_ready, rx_valid}, 8'h02);
  endtask
  task automatic t_tx2(input logic [7:0] a, input logic [7:0] b);
    tx_valid <= 1'b1;
    tx_data <= a;
    do @(negedge clk_sys); while (!tx_ready);
    @(posedge clk_sys);
    tx_data <= b;
    do @(negedge clk_sys); while (!tx_ready);
    @(posedge clk_sys);
    tx_valid <= 1'b0;
    repeat (1000) if (u_suart_host.got_q.size() < 2) @(posedge clk_sys);
    check(u_suart_host.got_q.pop_front(), a);
    check(u_suart_host.got_q.pop_front(), b);
  endtask
  task automatic t_ce;
    ce <= 1'b0;
    tx_valid <= 1'b1;
    tx_data <= 8'h55;
    repeat (20) @(posedge clk_sys);
    check(port_out, 8'h20);
    tx_valid <= 1'b0;
    @(posedge clk_sys);
    ce <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check(port_out, 8'h20);
  endtask
  task automatic t_rx(input logic [7:0] d, input logic stop);
    u_suart_host.send(d, stop);
    check({7'h00, rx_valid}, 8'h01);
    check(rx_data, d);
    rx_ready <= 1'b1;
    @(posedge clk_sys);
    rx_ready <= 1'b0;
    @(posedge clk_sys);
    check({7'h00, rx_valid}, 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_init;
    t_ce;
    t_tx2(8'hA5, 8'h3C);
    t_rx(8'hC3, 1'b1);
    t_rx(8'h5A, 1'b0);
    t_rx(8'h81, 1'b1);
    fast_rate <= 1'b1;
    t_tx2(8'h0F, 8'hF0);
    t_rx(8'h96, 1'b1);
    print_verdict;
  end
  initial begin
    #30000;
    err_count++;
    print_verdict;
  end
endmodule // suart_core_tb
